// ===== src/pss_ctl.sv
// controller end: turns queued user commands into sram pin cycles
`timescale 1ns/1ps
module pss_ctl
    import pss_pkg::*;
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire logic cmd_write_i,
    input wire logic [pss_pkg::PSS_ADDR_W-1:0] cmd_addr_i,
    input wire logic [pss_pkg::PSS_LANES-1:0] cmd_lanes_n_i,
    input wire logic [pss_pkg::PSS_DATA_W-1:0] cmd_wdata_i,
    input wire logic hold_i,
    input wire logic sleep_i,
    output logic rd_valid_o,
    output logic [pss_pkg::PSS_DATA_W-1:0] rd_data_o,
    pss_if.ctl bus
);
    import pss_pkg::*;
    localparam int CW = 1 + PSS_ADDR_W + PSS_LANES + PSS_DATA_W;
    typedef struct packed {
        logic [PSS_ADDR_W-1:0] addr;
        logic wsel;
        logic [PSS_LANES-1:0] bw;
        logic sel;
        logic hold_n;
        logic sleep;
        logic [PSS_PIPE-1:0] wpipe;
        logic [PSS_PIPE-1:0] rpipe;
        logic [PSS_DATA_W-1:0] wd1;
        logic [PSS_DATA_W-1:0] wd2;
        logic [PSS_DATA_W-1:0] dq_out;
        logic dq_oe;
        logic oe_n;
        logic rvalid;
        logic [PSS_DATA_W-1:0] rdata;
    } pss_ctl_st_t;
    pss_ctl_st_t s_q;
    pss_ctl_st_t s_d;
    logic f_valid;
    logic f_ready;
    logic [CW-1:0] f_data;
    logic f_write;
    logic [PSS_ADDR_W-1:0] f_addr;
    logic [PSS_LANES-1:0] f_lanes;
    logic [PSS_DATA_W-1:0] f_wd;
    logic run;
    // commands queue up; a held or sleeping bus stalls the queue output
    pss_fifo #(.WIDTH(CW), .DEPTH(PSS_FIFO_DEPTH)) pss_fifo_i (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .in_valid_i(cmd_valid_i),
        .in_ready_o(cmd_ready_o),
        .in_data_i({cmd_write_i, cmd_addr_i, cmd_lanes_n_i, cmd_wdata_i}),
        .out_valid_o(f_valid),
        .out_ready_i(f_ready),
        .out_data_o(f_data)
    );
    assign {f_write, f_addr, f_lanes, f_wd} = f_data;
    // the edge is only enabled if the pins seen at it say so
    assign run = s_q.hold_n && !s_q.sleep;
    assign f_ready = !hold_i && !sleep_i;
    // pin cycle build; pipelines advance only on enabled edges
    always_comb
    begin
        s_d = s_q;
        s_d.hold_n = !hold_i;
        s_d.sleep = sleep_i;
        s_d.rvalid = 1'b0;
        if (run)
        begin
            s_d.wpipe = {s_q.wpipe[0], s_q.sel && s_q.wsel};
            s_d.rpipe = {s_q.rpipe[0], s_q.sel && !s_q.wsel};
            s_d.wd2 = s_q.wd1;
            s_d.dq_oe = s_q.wpipe[0]; // drive data on write phase
            s_d.dq_out = s_q.wd2;
            s_d.oe_n = !s_q.rpipe[0]; // device drivers open only for read data
            if (s_q.rpipe[1])
            begin
                s_d.rvalid = 1'b1;
                s_d.rdata = bus.dq;
            end
        end
        if (f_ready)
        begin
            s_d.sel = f_valid;
            s_d.wsel = f_valid && f_write;
            s_d.addr = f_valid ? f_addr : '0;
            s_d.bw = (f_valid && f_write) ? f_lanes : '1;
            s_d.wd1 = f_wd;
        end
    end
    // state register, synchronous reset
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            s_q <= '0;
            s_q.bw <= '1;
            s_q.oe_n <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end
    assign rd_valid_o = s_q.rvalid;
    assign rd_data_o = s_q.rdata;
    assign bus.addr = s_q.addr;
    assign bus.write_sel = s_q.wsel;
    assign bus.byte_lane_write_n = s_q.bw;
    assign bus.cycle_hold_n = s_q.hold_n;
    assign bus.select_low_first = !s_q.sel;
    assign bus.select_high = s_q.sel;
    assign bus.select_low_second = !s_q.sel;
    assign bus.out_enable_n = s_q.oe_n;
    assign bus.burst_mode = PSS_MODE_LINEAR;
    assign bus.burst_adv = 1'b0;
    assign bus.sleep_request = s_q.sleep;
    assign bus.dq_ctl_o = s_q.dq_out;
    assign bus.dq_ctl_oe = s_q.dq_oe;
endmodule

// ===== src/pss_fifo.sv
// parameterised valid/ready fifo for the controller data path
`timescale 1ns/1ps
module pss_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 16
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;
    assign in_ready_o = (cnt_q != DEPTH[AW:0]);
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rd_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    // storage has no reset, pointers do
    always_ff @(posedge clock_i)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data_i;
        end
        if (sys_rst_i)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule

// ===== src/pss_if.sv
// pin bundle between the sram device end and the controller end
`timescale 1ns/1ps
interface pss_if;
    import pss_pkg::*;
    logic [PSS_ADDR_W-1:0] addr;
    logic write_sel;
    logic [PSS_LANES-1:0] byte_lane_write_n;
    logic cycle_hold_n;
    logic select_low_first;
    logic select_high;
    logic select_low_second;
    logic out_enable_n;
    logic burst_mode;
    logic burst_adv;
    logic sleep_request;
    logic [PSS_DATA_W-1:0] dq_ctl_o;
    logic dq_ctl_oe;
    logic [PSS_DATA_W-1:0] dq_mem_o;
    logic dq_mem_oe;
    logic [PSS_DATA_W-1:0] dq;
    // resolved bus level, device wins whenever it drives, then controller if it drives, zero when neither does
    assign dq = dq_mem_oe ? dq_mem_o : (dq_ctl_oe ? dq_ctl_o : '0);
    modport mem
    (
        input addr, write_sel, byte_lane_write_n, cycle_hold_n, select_low_first,
        input select_high, select_low_second, out_enable_n, burst_mode, burst_adv,
        input sleep_request, dq,
        output dq_mem_o, dq_mem_oe
    );
    modport ctl
    (
        output addr, write_sel, byte_lane_write_n, cycle_hold_n, select_low_first,
        output select_high, select_low_second, out_enable_n, burst_mode, burst_adv,
        output sleep_request, dq_ctl_o, dq_ctl_oe,
        input dq
    );
endinterface

// ===== src/pss_mem.sv
// device end: pipelined synchronous burst sram model in rtl
`timescale 1ns/1ps
module pss_mem
    import pss_pkg::*;
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    pss_if.mem bus
);
    import pss_pkg::*;
    localparam int WORDS = 1 << PSS_ADDR_W;
    typedef struct packed {
        pss_op_t op1;
        logic [PSS_ADDR_W-1:0] a1;
        logic [PSS_LANES-1:0] bw1;
        pss_op_t op2;
        logic [PSS_ADDR_W-1:0] a2;
        logic [PSS_LANES-1:0] bw2;
        logic [PSS_ADDR_W-1:0] base;
        logic [1:0] cnt;
        logic mode;
        pss_op_t last;
        logic [PSS_DATA_W-1:0] dout;
        logic drive;
    } pss_mem_st_t;
    pss_mem_st_t s_q;
    pss_mem_st_t s_d;
    logic [PSS_DATA_W-1:0] rd_word;
    logic fwd_hit;
    logic sel_ok;
    logic [1:0] nxt_cnt;
    logic [PSS_ADDR_W-1:0] cur_addr;
    logic wr_now;
    // burst offset: linear counts, interleaved xors the count in
    function automatic logic [PSS_ADDR_W-1:0] burst_addr(
        input logic [PSS_ADDR_W-1:0] base, input logic [1:0] c, input logic mode);
        logic [1:0] low;
        low = (mode == PSS_MODE_LINEAR) ? base[1:0] + c : base[1:0] ^ c;
        return {base[PSS_ADDR_W-1:2], low};
    endfunction
    assign sel_ok = !bus.select_low_first && bus.select_high && !bus.select_low_second;
    assign nxt_cnt = s_q.cnt + 2'h1;
    assign cur_addr = burst_addr(s_q.base, nxt_cnt, s_q.mode);
    // write now: clock qualifier asserted, not asleep, and a write in the data stage
    assign wr_now = bus.cycle_hold_n && !bus.sleep_request && s_q.op2 == PSS_OP_WRITE;
    // next-state: command stage feeds data stage at the next enabled edge
    always_comb
    begin
        s_d = s_q;
        if (bus.cycle_hold_n && !bus.sleep_request)
        begin
            s_d.op2 = s_q.op1;
            s_d.a2 = s_q.a1;
            s_d.bw2 = s_q.bw1;
            s_d.op1 = PSS_OP_IDLE;
            if (bus.burst_adv && s_q.last != PSS_OP_IDLE)
            begin
                s_d.op1 = s_q.last;
                s_d.a1 = cur_addr;
                s_d.cnt = nxt_cnt;
                s_d.bw1 = bus.byte_lane_write_n;
            end
            else if (!bus.burst_adv && sel_ok)
            begin
                s_d.op1 = bus.write_sel ? PSS_OP_WRITE : PSS_OP_READ;
                s_d.a1 = bus.addr;
                s_d.bw1 = bus.byte_lane_write_n;
                s_d.base = bus.addr;
                s_d.cnt = 2'h0;
                s_d.mode = bus.burst_mode;
                s_d.last = s_d.op1;
            end
            else if (!bus.burst_adv)
            begin
                s_d.last = PSS_OP_IDLE;
            end
            // output register loads read data, drivers off for writes
            s_d.drive = (s_q.op1 == PSS_OP_READ);
            if (s_q.op1 == PSS_OP_READ)
            begin
                s_d.dout = rd_word;
            end
        end
    end
    // state register, synchronous reset
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end
    // a write landing at this edge feeds a read of the same word directly,
    // otherwise a write followed at once by a read would return stale data
    assign fwd_hit = wr_now && (s_q.a2 == s_q.a1);
    // one array per lane keeps each lane's self-timed write in its own process
    generate
        for (genvar l = 0; l < PSS_LANES; l++)
        begin : g_lane
            logic [PSS_LANE_W-1:0] lane_q [WORDS];
            always_ff @(posedge clock_i)
            begin
                if (wr_now && !s_q.bw2[l])
                begin
                    lane_q[s_q.a2] <= bus.dq[l*PSS_LANE_W +: PSS_LANE_W];
                end
            end
            assign rd_word[l*PSS_LANE_W +: PSS_LANE_W] = (fwd_hit && !s_q.bw2[l]) ?
                bus.dq[l*PSS_LANE_W +: PSS_LANE_W] : lane_q[s_q.a1];
        end
    endgenerate
    assign bus.dq_mem_o = s_q.dout;
    assign bus.dq_mem_oe = s_q.drive && !bus.out_enable_n; // async gate
endmodule

// ===== src/pss_pkg.sv
// shared constants and types for the pipelined sync sram port
package pss_pkg;
    localparam int PSS_ADDR_W = 10;
    localparam int PSS_DATA_W = 36;
    localparam int PSS_LANES = 4;
    localparam int PSS_LANE_W = PSS_DATA_W / PSS_LANES;
    localparam int PSS_PIPE = 2;
    localparam int PSS_FIFO_DEPTH = 16;
    localparam logic [1:0] PSS_BURST_LEN = 2'h3;
    localparam logic PSS_MODE_LINEAR = 1'h1;
    localparam logic PSS_MODE_INTERLEAVED = 1'h0;
    typedef enum logic [1:0]
    {
        PSS_OP_IDLE = 2'h0,
        PSS_OP_READ = 2'h1,
        PSS_OP_WRITE = 2'h3
    } pss_op_t;
endpackage

// ===== tb/pss_chk.sv
// pin level assertions between the sram end and the controller end
`timescale 1ns/1ps
module pss_chk
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic [pss_pkg::PSS_ADDR_W-1:0] addr,
    input wire logic write_sel,
    input wire logic [pss_pkg::PSS_LANES-1:0] byte_lane_write_n,
    input wire logic cycle_hold_n,
    input wire logic select_low_first,
    input wire logic select_high,
    input wire logic select_low_second,
    input wire logic sleep_request,
    input wire logic out_enable_n,
    input wire logic dq_ctl_oe,
    input wire logic dq_mem_oe
);
    import pss_pkg::*;
    // a cycle counts only with all selects on and the edge not frozen
    wire sel = !select_low_first && select_high && !select_low_second;
    wire en = cycle_hold_n && !sleep_request;
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (sys_rst_i);
    // two drivers at once would fight on the shared data bus
    no_contention_a: assert property (!(dq_mem_oe && dq_ctl_oe))
        else $error("both ends drive the data bus");
    read_phase_a: assert property (sel && en && !write_sel ##1 en |=> dq_mem_oe)
        else $error("read data phase missing");
    write_phase_a: assert property (sel && en && write_sel ##1 en |=> dq_ctl_oe && !dq_mem_oe)
        else $error("write data phase wrong");
    desel_quiet_a: assert property (!sel && en ##1 en |=> !dq_mem_oe && !dq_ctl_oe)
        else $error("deselected cycle drove data");
    read_cause_a: assert property ($rose(dq_mem_oe) && $past(en) |-> $past(sel && !write_sel, 2))
        else $error("device drove data without a read");
    // a frozen edge must leave both drive enables untouched
    hold_freeze_a: assert property (!en |=> $stable(dq_mem_oe) && $stable(dq_ctl_oe))
        else $error("frozen edge changed drive state");
    pins_stand_a: assert property (!cycle_hold_n |-> $stable(addr) && $stable(byte_lane_write_n))
        else $error("pins moved while held");
    oe_gate_a: assert property (out_enable_n |-> !dq_mem_oe)
        else $error("device drove data with output enable off");
    reset_idle_a: assert property (disable iff (1'b0) sys_rst_i |=> !select_high && &byte_lane_write_n && !dq_mem_oe)
        else $error("pins not idle after reset");
    cover property (sel && en && write_sel ##1 sel && en && !write_sel);
    cover property (sel && en && !write_sel);
    cover property (!cycle_hold_n);
    cover property (sleep_request);
endmodule

// ===== tb/tb_pipelined_sync_sram_port.sv
// self-checking bench joining the controller end to the sram end
`timescale 1ns/1ps
module tb_pipelined_sync_sram_port;
    import pss_pkg::*;
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic cmd_valid_i = 1'b0;
    logic cmd_write_i = 1'b0;
    logic [PSS_ADDR_W-1:0] cmd_addr_i = '0;
    logic [PSS_LANES-1:0] cmd_lanes_n_i = '0;
    logic [PSS_DATA_W-1:0] cmd_wdata_i = '0;
    logic hold_i = 1'b0;
    logic sleep_i = 1'b0;
    logic cmd_ready_o;
    logic rd_valid_o;
    logic [PSS_DATA_W-1:0] rd_data_o;
    logic [PSS_DATA_W-1:0] mdl [0:1023];
    logic [PSS_DATA_W-1:0] exp_q[$];
    logic [PSS_DATA_W-1:0] got_q[$];
    int bad_count = 0;
    int comparisons = 0;
    always #12.5 clock_i = ~clock_i;
    pss_if pss_if_i ();
    pss_mem pss_mem_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .bus(pss_if_i.mem));
    pss_ctl pss_ctl_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .cmd_valid_i(cmd_valid_i),
        .cmd_ready_o(cmd_ready_o), .cmd_write_i(cmd_write_i), .cmd_addr_i(cmd_addr_i),
        .cmd_lanes_n_i(cmd_lanes_n_i), .cmd_wdata_i(cmd_wdata_i), .hold_i(hold_i),
        .sleep_i(sleep_i), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .bus(pss_if_i.ctl));
    pss_chk pss_chk_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .addr(pss_if_i.addr),
        .write_sel(pss_if_i.write_sel), .byte_lane_write_n(pss_if_i.byte_lane_write_n),
        .cycle_hold_n(pss_if_i.cycle_hold_n), .select_low_first(pss_if_i.select_low_first),
        .select_high(pss_if_i.select_high), .select_low_second(pss_if_i.select_low_second),
        .sleep_request(pss_if_i.sleep_request), .out_enable_n(pss_if_i.out_enable_n),
        .dq_ctl_oe(pss_if_i.dq_ctl_oe),
        .dq_mem_oe(pss_if_i.dq_mem_oe));
    // collect every returned read word
    always @(posedge clock_i)
        if (rd_valid_o === 1'b1)
            got_q.push_back(rd_data_o);
    task automatic check(input logic [PSS_DATA_W-1:0] got, input logic [PSS_DATA_W-1:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // offer one command; dropped again if not taken within a few edges
    task automatic send(input logic wr, input logic [PSS_ADDR_W-1:0] a,
        input logic [PSS_LANES-1:0] ln, input logic [PSS_DATA_W-1:0] d, output bit ok);
        int n;
        cmd_valid_i <= 1'b1;
        cmd_write_i <= wr;
        cmd_addr_i <= a;
        cmd_lanes_n_i <= ln;
        cmd_wdata_i <= d;
        ok = 1'b0;
        for (n = 0; n < 8 && !ok; n++)
        begin
            @(posedge clock_i);
            ok = (cmd_ready_o === 1'b1);
        end
        if (!ok)
            cmd_valid_i <= 1'b0;
        else if (!wr)
            exp_q.push_back(mdl[a]);
        else
            for (int i = 0; i < PSS_LANES; i++)
                if (!ln[i])
                    mdl[a][i*PSS_LANE_W +: PSS_LANE_W] = d[i*PSS_LANE_W +: PSS_LANE_W];
    endtask
    // wait for all reads to return, then compare them in order
    task automatic drain(input string name);
        int n;
        cmd_valid_i <= 1'b0;
        for (n = 0; n < 40 && got_q.size() < exp_q.size(); n++)
            @(posedge clock_i);
        check(got_q.size(), exp_q.size());
        while (got_q.size() > 0 && exp_q.size() > 0)
            check(got_q.pop_front(), exp_q.pop_front());
        got_q.delete();
        exp_q.delete();
        $display("test %s done", name);
    endtask
    // full words, then single lanes, no lane, and write then read back to back
    task automatic t_lanes;
        bit ok;
        for (int a = 0; a < 5; a++)
            send(1'b1, a, 4'h0, 36'h123456789 + a, ok);
        for (int a = 0; a < 4; a++)
            send(1'b1, a, ~(4'h1 << a), 36'hfedcba987, ok);
        send(1'b1, 4, 4'hf, 36'h0aa55aa55, ok);
        for (int a = 0; a < 5; a++)
        begin
            send(1'b1, 8 + a, 4'h0, 36'h00f0f0f0f ^ a, ok);
            send(1'b0, 8 + a, 4'h0, 36'h0, ok);
            send(1'b0, a, 4'h0, 36'h0, ok);
        end
        drain("lanes");
    endtask
    // stall the far side until the buffer refuses, then drain with freezes
    task automatic t_fill;
        bit ok;
        int k;
        hold_i <= 1'b1;
        k = 0;
        do
        begin
            send(1'b1, 16 + k, 4'h0, 36'h500000000 | k, ok);
            k++;
        end
        while (ok && k < 40);
        check(k > PSS_FIFO_DEPTH, 1'b1);
        // let the refused offer lapse before the queue is released
        @(posedge clock_i);
        hold_i <= 1'b0;
        for (int a = 0; a < k - 1; a++)
        begin
            send(1'b0, 16 + a, 4'h0, 36'h0, ok);
            check(ok, 1'b1);
        end
        // freeze with reads in flight: sleep first, then hold
        cmd_valid_i <= 1'b0;
        sleep_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        sleep_i <= 1'b0;
        hold_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        hold_i <= 1'b0;
        drain("fill");
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clock_i);
        bad_count++;
        close_out();
    end
    initial
    begin
        repeat (20) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(posedge clock_i);
        t_lanes();
        t_fill();
        close_out();
    end
endmodule
